/* File: bench/sram_link_monitor.sv */
// Checker for the pins between the controller end and the device end.
// Assumes one clock domain; instantiated beside the link interface.
`timescale 1ns/1ps
`default_nettype none

module sram_link_monitor #(
	parameter int LANES = 2
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic ctrl_address_strobe_n,
	input wire logic proc_address_strobe_n,
	input wire logic burst_advance_n,
	input wire logic global_write_n,
	input wire logic byte_write_gate_n,
	input wire logic [LANES-1:0] byte_lane_write_n,
	input wire logic sleep_request,
	input wire logic output_drive_n,
	input wire logic dq_host_oe,
	input wire logic dq_dev_oe
);
	logic rd_go;
	logic wr_go;

	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);

	// Read and write cycles as the device samples them
	assign rd_go = !ctrl_address_strobe_n && global_write_n && (byte_write_gate_n || &byte_lane_write_n) && !sleep_request;
	assign wr_go = !global_write_n || (!byte_write_gate_n && !(&byte_lane_write_n));

	// A read drives one pipeline stage late, four beats back to back
	sequence four_beats;
		##2 dq_dev_oe [*4];
	endsequence
	sequence adv_run;
		!burst_advance_n [*3] ##1 burst_advance_n;
	endsequence

	chk_read_beats: assert property (rd_go |-> four_beats)
		else $error("read burst not driven four beats two edges after the strobe");
	chk_drive_late: assert property (rd_go && !dq_dev_oe |=> !dq_dev_oe)
		else $error("read data driven before the next edge");
	chk_adv_run: assert property (rd_go |=> adv_run)
		else $error("burst advance not low for three beats");
	chk_write_quiet: assert property (wr_go |=> !dq_dev_oe [*2])
		else $error("device drove the bus after a write");
	chk_write_oe_high: assert property (dq_host_oe |-> output_drive_n && !dq_dev_oe)
		else $error("output enable active while write data driven");
	chk_write_kind: assert property (wr_go |-> proc_address_strobe_n && burst_advance_n)
		else $error("write without processor strobe and advance high");
	chk_sleep_off: assert property (sleep_request |=> !dq_dev_oe)
		else $error("device drove the bus while asleep");
	chk_sleep_idle: assert property ($rose(sleep_request) |-> ctrl_address_strobe_n && !dq_dev_oe)
		else $error("sleep entered with an access pending");
	chk_wake_wait: assert property ($fell(sleep_request) |-> ctrl_address_strobe_n ##1 ctrl_address_strobe_n)
		else $error("strobe within two cycles of wake");
endmodule

`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench: controller end and device end joined by the link.
// Assumes the design files are compiled first; a run is a couple of hundred cycles, and the watchdog stops it at 3000.
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import sram_link_pkg::*;
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [1:0] lanes;
		logic [17:0] data;
		logic lin;
	} row_t;
	// Full writes, partial writes, reads in both burst orders, then a write held behind them
	localparam row_t rows [10] = '{
		'{1'b1, 8'h10, 2'h3, 18'h12345, 1'b0}, '{1'b1, 8'h11, 2'h3, 18'h23456, 1'b0},
		'{1'b1, 8'h12, 2'h3, 18'h34567, 1'b0}, '{1'b1, 8'h13, 2'h3, 18'h01234, 1'b0},
		'{1'b1, 8'h11, 2'h1, 18'h3ffff, 1'b0}, '{1'b1, 8'h12, 2'h2, 18'h00000, 1'b0},
		'{1'b0, 8'h11, 2'h0, 18'h00000, 1'b1}, '{1'b0, 8'h12, 2'h0, 18'h00000, 1'b0},
		'{1'b0, 8'h13, 2'h0, 18'h00000, 1'b1}, '{1'b1, 8'h10, 2'h1, 18'h00abc, 1'b0}};
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic cmd_valid = 1'b0;
	logic linear_mode = 1'b0;
	logic sleep_cmd = 1'b0;
	cmd_kind_t cmd_kind = CMD_READ;
	logic [7:0] cmd_addr = 8'h00;
	logic [1:0] cmd_lanes = 2'h0;
	logic [17:0] cmd_data = 18'h0;
	logic cmd_ready, rd_valid, sleeping, asleep, reading;
	logic [17:0] rd_data;
	logic [17:0] mem [256];
	logic [17:0] exp_q [$];
	int n_mismatch = 0;
	int total_checks = 0;

	always #5 clock = ~clock;

	sram_link_if #(.ADDR_W(8)) sram_link_if_i ();
	sram_host_end #(.ADDR_W(8)) sram_host_end_i (.clock(clock), .arst_n(arst_n), .link(sram_link_if_i),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr),
		.cmd_lanes(cmd_lanes), .cmd_data(cmd_data), .linear_mode(linear_mode), .sleep_cmd(sleep_cmd),
		.rd_data(rd_data), .rd_valid(rd_valid), .sleeping(sleeping));
	sram_device_end #(.ADDR_W(8)) sram_device_end_i (.clock(clock), .arst_n(arst_n), .link(sram_link_if_i),
		.asleep(asleep), .reading(reading));
	sram_link_monitor #(.LANES(2)) sram_link_monitor_i (.clock(clock), .arst_n(arst_n),
		.ctrl_address_strobe_n(sram_link_if_i.ctrl_address_strobe_n),
		.proc_address_strobe_n(sram_link_if_i.proc_address_strobe_n),
		.burst_advance_n(sram_link_if_i.burst_advance_n), .global_write_n(sram_link_if_i.global_write_n),
		.byte_write_gate_n(sram_link_if_i.byte_write_gate_n), .byte_lane_write_n(sram_link_if_i.byte_lane_write_n),
		.sleep_request(sram_link_if_i.sleep_request), .output_drive_n(sram_link_if_i.output_drive_n),
		.dq_host_oe(sram_link_if_i.dq_host_oe), .dq_dev_oe(sram_link_if_i.dq_dev_oe));

	task automatic check(string name, logic [17:0] seen, logic [17:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Inputs change a little after the rising edge
	task automatic tick();
		@(posedge clock);
		#1;
	endtask

	// Hold one command until taken; valid stays up so back-to-back sends never drop it
	task automatic send(row_t r);
		logic [1:0] lo;
		cmd_valid = 1'b1;
		cmd_kind = cmd_kind_t'(r.wr);
		cmd_addr = r.addr;
		cmd_lanes = r.lanes;
		cmd_data = r.data;
		linear_mode = r.lin;
		for (int i = 0; i < 50 && cmd_ready !== 1'b1; i++) tick();
		check("cmd_ready", 18'(cmd_ready), 18'h1);
		tick();
		for (int l = 0; l < 2; l++) if (r.wr && r.lanes[l]) mem[r.addr][l*9 +: 9] = r.data[l*9 +: 9];
		for (int i = 0; i < 4 && !r.wr; i++) begin
			lo = r.lin ? 2'(r.addr[1:0] + 2'(i)) : (r.addr[1:0] ^ 2'(i));
			exp_q.push_back(mem[{r.addr[7:2], lo}]);
		end
	endtask

	// Wait, bounded, until every expected beat has come back
	task automatic drain();
		for (int i = 0; i < 400 && exp_q.size() != 0; i++) tick();
		check("beats_left", 18'(exp_q.size()), 18'h0);
	endtask

	// Beats are compared in arrival order; the pulse is seen once at the falling edge
	always @(negedge clock) begin
		if (rd_valid === 1'b1) begin
			if (exp_q.size() == 0) check("extra_beat", 18'h1, 18'h0);
			else check("rd_data", rd_data, exp_q.pop_front());
		end
	end

	initial begin
		repeat (3000) @(posedge clock);
		n_mismatch++;
		stop_test();
	end

	initial begin
		repeat (16) @(posedge clock);
		#1 arst_n = 1'b1;
		check("sleeping_rst", 18'(sleeping), 18'h0);
		foreach (rows[k]) send(rows[k]);
		cmd_valid = 1'b0;
		drain();
		// Queue fills while the link sleeps; nothing may come out until wake
		sleep_cmd = 1'b1;
		for (int i = 0; i < 20 && sleeping !== 1'b1; i++) tick();
		tick();
		tick();
		check("asleep", 18'(asleep), 18'h1);
		check("reading", 18'(reading), 18'h0);
		for (int k = 0; k < 16; k++) send(row_t'{1'b0, 8'h10 + 8'(k % 4), 2'h0, 18'h0, k[0]});
		cmd_valid = 1'b0;
		repeat (10) tick();
		check("full_ready", 18'(cmd_ready), 18'h0);
		check("sleep_beats", 18'(exp_q.size()), 18'h40);
		sleep_cmd = 1'b0;
		drain();
		// Partial write straight after reads, then read the block back
		send(row_t'{1'b1, 8'h13, 2'h2, 18'h3fe00, 1'b0});
		send(row_t'{1'b0, 8'h10, 2'h0, 18'h0, 1'b1});
		cmd_valid = 1'b0;
		drain();
		// Second reset mid-run must leave the bus released
		arst_n = 1'b0;
		#1;
		check("ready_rst2", 18'(cmd_ready), 18'h1);
		check("bus_rst2", 18'(reading), 18'h0);
		tick();
		arst_n = 1'b1;
		tick();
		stop_test();
	end
endmodule

`default_nettype wire

/* File: verilog/sram_device_end.sv */
// Pipelined burst memory device: registered controls, 2-bit burst counter,
// per-lane writes, double-cycle deselect, sleep input.
// Assumes every link input is synchronous to clock; the array has no reset.
`timescale 1ns/1ps
`default_nettype none

`include "sram_link_map.svh"

module sram_device_end #(
	parameter int ADDR_W = `ADDR_W_DEF,
	parameter int LANES = `LANES_DEF,
	parameter int LANE_W = `LANE_W_DEF
) (
	input wire logic clock,
	input wire logic arst_n,
	sram_link_if.device link,
	output logic asleep,
	output logic reading
);
	import sram_link_pkg::*;

	localparam int DW = LANES * LANE_W;
	localparam int CW = `BURST_CNT_W;

	// Elaboration check: counter wraps inside the address, lanes exist
	if (ADDR_W <= CW || LANES < 1 || LANE_W < 1) begin : g_bad_params
		$error("sram_device_end: unsupported parameter values");
	end

	typedef struct packed {
		logic sleep_seen;
		logic active;
		logic [ADDR_W-1:0] base;
		logic [CW-1:0] cnt;
		logic last_rd;
		logic rd_pend;
		logic [ADDR_W-1:0] rd_addr;
		logic [DW-1:0] q;
		logic q_oe;
	} dev_state_t;

	dev_state_t st_r;
	dev_state_t st_nxt;

	// Storage array, one word per address
	logic [DW-1:0] mem [0:(1<<ADDR_W)-1];

	logic selected;
	logic strobe;
	logic load;
	logic desel;
	logic advance;
	logic act;
	logic [LANES-1:0] lanes_wr;
	logic wr_any;
	logic wr_now;
	logic rd_now;
	logic [CW-1:0] cur_cnt;
	logic [ADDR_W-1:0] cur_base;
	logic [CW-1:0] low_bits;
	logic [ADDR_W-1:0] cur_addr;

	// Decode of the controls sampled at this edge
	always_comb begin
		st_nxt = st_r;
		st_nxt.sleep_seen = link.sleep_request;
		selected = ~link.chip_select_n & ~link.secondary_select_n & link.secondary_select_hi;
		strobe = ~link.proc_address_strobe_n | ~link.ctrl_address_strobe_n;
		load = strobe & selected;
		desel = strobe & ~selected;
		advance = ~strobe & ~link.burst_advance_n & st_r.active;
		// Global write covers every lane; otherwise the gate qualifies each lane
		if (!link.global_write_n) begin
			lanes_wr = '1;
		end else if (!link.byte_write_gate_n) begin
			lanes_wr = ~link.byte_lane_write_n;
		end else begin
			lanes_wr = '0;
		end
		wr_any = |lanes_wr;
		// Burst counter: reload on a selected strobe, step on advance, hold otherwise
		if (load) begin
			cur_cnt = '0;
			cur_base = link.addr;
		end else if (advance) begin
			cur_cnt = st_r.cnt + CW'(1);
			cur_base = st_r.base;
		end else begin
			cur_cnt = st_r.cnt;
			cur_base = st_r.base;
		end
		low_bits = link.linear_burst ? cur_base[CW-1:0] + cur_cnt : cur_base[CW-1:0] ^ cur_cnt;
		cur_addr = {cur_base[ADDR_W-1:CW], low_bits};
		act = (load | (st_r.active & ~desel)) & ~st_r.sleep_seen;
		// A processor strobe never starts a write, so a write needs it high
		wr_now = act & link.proc_address_strobe_n & wr_any;
		// A suspend after a write keeps the bus idle; after a read it repeats
		rd_now = act & ~wr_any & (load | advance | st_r.last_rd);
		st_nxt.active = act;
		if (act) begin
			st_nxt.base = cur_base;
			st_nxt.cnt = cur_cnt;
		end
		st_nxt.last_rd = rd_now;
		st_nxt.rd_pend = rd_now;
		st_nxt.rd_addr = cur_addr;
		// Data leaves the array one edge after its address was taken
		if (st_r.rd_pend) begin
			st_nxt.q = mem[st_r.rd_addr];
		end
		// Drive only from a registered enable, so never before the next edge;
		// even with a read in flight the enable drops two edges after deselect
		st_nxt.q_oe = st_r.rd_pend & ~link.output_drive_n & ~wr_any & ~st_r.sleep_seen;
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Lane-wise array write; lanes not enabled keep their old bits
	always_ff @(posedge clock) begin
		if (wr_now) begin
			for (int l = 0; l < LANES; l++) begin
				if (lanes_wr[l]) begin
					mem[cur_addr][l*LANE_W +: LANE_W] <= link.dq[l*LANE_W +: LANE_W];
				end
			end
		end
	end

	assign link.dq_dev_o = st_r.q;
	assign link.dq_dev_oe = st_r.q_oe;
	assign asleep = st_r.sleep_seen;
	assign reading = st_r.q_oe;
endmodule

`default_nettype wire

/* File: verilog/sram_host_end.sv */
// Memory controller end: queues user commands in a FIFO and plays them on the
// link as single writes and four-beat reads; manages sleep entry and exit.
// Assumes the device end samples the same clock edges as this end.
`timescale 1ns/1ps
`default_nettype none

`include "sram_link_map.svh"

module cmd_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = `CMD_FIFO_DEPTH
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("cmd_fifo: depth must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] store [0:DEPTH-1];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0] count_r;
	logic [AW:0] count_nxt;
	logic not_full_r;
	logic push;
	logic pop;

	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
	// Ready comes from a flop so the user side sees no compare path
	assign in_ready = not_full_r;
	assign out_valid = (count_r != '0);
	assign out_data = store[rd_ptr_r];

	// Pointers and fill level; a full queue stalls the user side
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
			not_full_r <= 1'b1;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + AW'(1);
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + AW'(1);
			end
			count_r <= count_nxt;
			not_full_r <= (count_nxt != (AW+1)'(DEPTH));
		end
	end

	always_ff @(posedge clock) begin
		if (push) begin
			store[wr_ptr_r] <= in_data;
		end
	end
endmodule

// Contract
// - High sleep request deselects and holds sleep
// - Asleep, inputs ignored within two clocks
// - Controller waits two clocks after wake
// - Sleep only after pending accesses finish
// - Output enable drives only after next edge
// - Outputs off within two cycles of deselect
// - Controller holds output enable high during writes
// - Advance high writes the loaded address
// - Global write or all lanes gives full write
// - Select needs all three enables true
// - Later burst beats use internal counter address
// - Write: some lane low, processor strobe high
// - Read: lanes high with a strobe or advance
// - After write bus idle until strobe/advance
// - Output enable ignored while any write sampled
module sram_host_end #(
	parameter int ADDR_W = `ADDR_W_DEF,
	parameter int LANES = `LANES_DEF,
	parameter int LANE_W = `LANE_W_DEF,
	parameter int DEPTH = `CMD_FIFO_DEPTH
) (
	input wire logic clock,
	input wire logic arst_n,
	sram_link_if.host link,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire sram_link_pkg::cmd_kind_t cmd_kind,
	input wire logic [ADDR_W-1:0] cmd_addr,
	input wire logic [LANES-1:0] cmd_lanes,
	input wire logic [LANES*LANE_W-1:0] cmd_data,
	input wire logic linear_mode,
	input wire logic sleep_cmd,
	output logic [LANES*LANE_W-1:0] rd_data,
	output logic rd_valid,
	output logic sleeping
);
	import sram_link_pkg::*;

	localparam int DW = LANES * LANE_W;
	localparam int FW = 2 + LANES + ADDR_W + DW;

	typedef struct packed {
		host_state_t state;
		logic [1:0] beats;
		logic [1:0] wait_cnt;
		logic [2:0] rd_shift;
		logic [ADDR_W-1:0] addr;
		logic ctrl_address_strobe_n_n;
		logic adv_n;
		logic gw_n;
		logic bwe_n;
		logic [LANES-1:0] bw_n;
		logic oe_n;
		logic sleep;
		logic linear;
		logic [DW-1:0] wdata;
		logic wdata_oe;
		logic [DW-1:0] rdata;
		logic rvalid;
	} host_st_t;

	host_st_t st_r;
	host_st_t st_nxt;
	logic q_valid;
	logic q_pop;
	logic [FW-1:0] q_data;
	logic issue_rd;
	logic q_is_wr;

	cmd_fifo #(.WIDTH(FW), .DEPTH(DEPTH)) u_fifo (
		.clock(clock),
		.arst_n(arst_n),
		.in_valid(cmd_valid),
		.in_ready(cmd_ready),
		.in_data({cmd_kind == CMD_WRITE, linear_mode, cmd_lanes, cmd_addr, cmd_data}),
		.out_valid(q_valid),
		.out_ready(q_pop),
		.out_data(q_data)
	);

	// Sequencer: every pin is set for the next edge from registered state
	always_comb begin
		st_nxt = st_r;
		q_pop = 1'b0;
		issue_rd = 1'b0;
		q_is_wr = q_data[FW-1];
		st_nxt.ctrl_address_strobe_n_n = 1'b1;
		st_nxt.adv_n = 1'b1;
		st_nxt.gw_n = 1'b1;
		st_nxt.bwe_n = 1'b1;
		st_nxt.bw_n = '1;
		st_nxt.wdata_oe = 1'b0;
		st_nxt.rd_shift = {st_r.rd_shift[1:0], 1'b0};
		st_nxt.rvalid = st_r.rd_shift[2];
		if (st_r.rd_shift[2]) begin
			st_nxt.rdata = link.dq;
		end
		unique case (st_r.state)
			HS_IDLE: begin
				// Sleep waits for the read pipe to empty
				if (sleep_cmd && st_r.rd_shift == '0) begin
					st_nxt.sleep = 1'b1;
					st_nxt.state = HS_SLEEP;
				end else if (q_valid && (!q_is_wr || st_r.rd_shift == '0)) begin
					q_pop = 1'b1;
					st_nxt.ctrl_address_strobe_n_n = 1'b0;
					st_nxt.addr = q_data[DW +: ADDR_W];
					// Burst order travels with the command, not the pin at pop time
					st_nxt.linear = q_data[FW-2];
					if (q_is_wr) begin
						// All lanes go through global write, others through the gate
						if (&q_data[DW+ADDR_W +: LANES]) begin
							st_nxt.gw_n = 1'b0;
						end else begin
							st_nxt.bwe_n = 1'b0;
							st_nxt.bw_n = ~q_data[DW+ADDR_W +: LANES];
						end
						st_nxt.wdata = q_data[DW-1:0];
						st_nxt.wdata_oe = 1'b1;
					end else begin
						issue_rd = 1'b1;
						st_nxt.beats = 2'(`BURST_BEATS - 1);
						st_nxt.state = HS_BURST;
					end
				end
			end
			HS_BURST: begin
				st_nxt.adv_n = 1'b0;
				issue_rd = 1'b1;
				st_nxt.beats = st_r.beats - 2'd1;
				if (st_r.beats == 2'd1) begin
					st_nxt.state = HS_IDLE;
				end
			end
			HS_SLEEP: begin
				if (!sleep_cmd) begin
					st_nxt.sleep = 1'b0;
					st_nxt.wait_cnt = 2'(`WAKE_WAIT_TKC);
					st_nxt.state = HS_WAKE;
				end
			end
			HS_WAKE: begin
				// Nothing is presented until the wake wait has passed
				st_nxt.wait_cnt = st_r.wait_cnt - 2'd1;
				if (st_r.wait_cnt == 2'd1) begin
					st_nxt.state = HS_IDLE;
				end
			end
			default: begin
				st_nxt.state = HS_IDLE;
			end
		endcase
		if (issue_rd) begin
			st_nxt.rd_shift[0] = 1'b1;
		end
		// Output enable only around reads; writes never overlap them
		st_nxt.oe_n = ~(issue_rd | st_r.rd_shift[0] | st_r.rd_shift[1]);
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= '0;
			st_r.state <= HS_IDLE;
			st_r.ctrl_address_strobe_n_n <= 1'b1;
			st_r.adv_n <= 1'b1;
			st_r.gw_n <= 1'b1;
			st_r.bwe_n <= 1'b1;
			st_r.bw_n <= '1;
			st_r.oe_n <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign link.addr = st_r.addr;
	assign link.chip_select_n = 1'b0;
	assign link.secondary_select_n = 1'b0;
	assign link.secondary_select_hi = 1'b1;
	assign link.proc_address_strobe_n = 1'b1;
	assign link.ctrl_address_strobe_n = st_r.ctrl_address_strobe_n_n;
	assign link.burst_advance_n = st_r.adv_n;
	assign link.global_write_n = st_r.gw_n;
	assign link.byte_write_gate_n = st_r.bwe_n;
	assign link.byte_lane_write_n = st_r.bw_n;
	assign link.output_drive_n = st_r.oe_n;
	assign link.sleep_request = st_r.sleep;
	assign link.linear_burst = st_r.linear;
	assign link.dq_host_o = st_r.wdata;
	assign link.dq_host_oe = st_r.wdata_oe;
	assign rd_data = st_r.rdata;
	assign rd_valid = st_r.rvalid;
	assign sleeping = st_r.sleep;
endmodule

`default_nettype wire

/* File: verilog/sram_link_if.sv */
// Pin bundle between the memory controller end and the memory device end.
// The shared data bus is resolved here from the device output enable alone.
`timescale 1ns/1ps
`default_nettype none

interface sram_link_if #(
	parameter int ADDR_W = 20,
	parameter int LANES = 2,
	parameter int LANE_W = 9
);
	logic [ADDR_W-1:0] addr;
	logic chip_select_n;
	logic secondary_select_n;
	logic secondary_select_hi;
	logic proc_address_strobe_n;
	logic ctrl_address_strobe_n;
	logic burst_advance_n;
	logic global_write_n;
	logic byte_write_gate_n;
	logic [LANES-1:0] byte_lane_write_n;
	logic output_drive_n;
	logic sleep_request;
	logic linear_burst;
	logic [LANES*LANE_W-1:0] dq_host_o;
	logic dq_host_oe;
	logic [LANES*LANE_W-1:0] dq_dev_o;
	logic dq_dev_oe;
	logic [LANES*LANE_W-1:0] dq;

	// Bus level: device data wins when it drives, otherwise the controller's
	assign dq = dq_dev_oe ? dq_dev_o : dq_host_o;

	modport host (
		output addr, chip_select_n, secondary_select_n, secondary_select_hi,
		output proc_address_strobe_n, ctrl_address_strobe_n, burst_advance_n,
		output global_write_n, byte_write_gate_n, byte_lane_write_n,
		output output_drive_n, sleep_request, linear_burst, dq_host_o, dq_host_oe,
		input dq, dq_dev_oe
	);
	modport device (
		input addr, chip_select_n, secondary_select_n, secondary_select_hi,
		input proc_address_strobe_n, ctrl_address_strobe_n, burst_advance_n,
		input global_write_n, byte_write_gate_n, byte_lane_write_n,
		input output_drive_n, sleep_request, linear_burst, dq, dq_host_oe,
		output dq_dev_o, dq_dev_oe
	);
endinterface

`default_nettype wire

/* File: verilog/sram_link_map.svh */
// Constants for the burst memory link: default widths, depths and timing counts.
// Assumes inclusion by bare name from the package and the design files.
`ifndef SRAM_LINK_MAP_SVH
`define SRAM_LINK_MAP_SVH

// Clock period in ns (100 MHz)
`define CLK_PERIOD_NS 10
// Address and data shape of the two-lane part
`define ADDR_W_DEF 20
`define LANES_DEF 2
`define LANE_W_DEF 9
// Burst counter width and beats per burst
`define BURST_CNT_W 2
`define BURST_BEATS 4
// Sleep entry bound and wake wait, in clock periods
`define SLEEP_IGNORE_TKC 2
`define WAKE_WAIT_TKC 2
// Deselect to outputs off, in clock periods
`define DESEL_OFF_TKC 2
// Command queue depth
`define CMD_FIFO_DEPTH 16

`endif

/* File: verilog/sram_link_pkg.sv */
// Types shared by both ends of the burst memory link.
// Assumes sram_link_map.svh sits on the include path.
`include "sram_link_map.svh"

package sram_link_pkg;
	// Controller sequencing states
	typedef enum logic [2:0] {
		HS_IDLE  = 3'b000,
		HS_BURST = 3'b001,
		HS_SLEEP = 3'b010,
		HS_WAKE  = 3'b011
	} host_state_t;

	// Kinds of queued command
	typedef enum logic {
		CMD_READ  = 1'b0,
		CMD_WRITE = 1'b1
	} cmd_kind_t;
endpackage
